// ### rtl/bce_consts.svh
// constants for the branch and control execution block
// assumes a 16-bit instruction stream with 32-bit byte addresses
`ifndef BCE_CONSTS_SVH
`define BCE_CONSTS_SVH

// address arithmetic, in bytes
`define BCE_INSN_SIZE      32'h0000_0002
`define BCE_CALL_SIZE      32'h0000_0004
`define BCE_PC_AHEAD       32'h0000_0004

// offset field widths, in bits; the fields count halfwords
`define BCE_OFS_BRANCH_W   11
`define BCE_OFS_COND_W     8
`define BCE_OFS_CALL_W     24

// register indices that a register branch may not name
`define BCE_REG_STACK      4'hd
`define BCE_REG_PC         4'hf

// reset values
`define BCE_MASK_RESET     1'b0
`define BCE_TBIT_RESET     1'b1

`endif

// ### rtl/bce_exec.sv
// branch and control execution stage of a small 32-bit core
// assumes decode supplies operands and flags on the same clock; the
// memory system reports mem_idle when no explicit access is in flight
//
// Summary of operation
// [RULE_01] branch to pc-relative label or register target
// [RULE_02] calls write next instruction address to r14
// [RULE_03] register branch with target bit0 zero faults
// [RULE_04] link value always has bit0 set
// [RULE_05] offsets: 2 KB, -256/+254 bytes, 16 MB
// [RULE_06] target bit0 goes to t bit, cleared
// [RULE_07] software never names sp or pc as target
// [RULE_08] only the conditional branch tests flags
// [RULE_09] branches leave condition flags unchanged
// [RULE_10] breakpoint enters debug state, immediate ignored
// [RULE_11] breakpoint without debugger raises fatal fault
// [RULE_12] mask set disables, mask clear enables interrupts
// [RULE_13] unmaskable interrupt ignores the mask bit
// [RULE_14] mask, fence, breakpoint leave flags unchanged
// [RULE_15] order fence: earlier accesses observed before later
// [RULE_16] order fence never stalls non-memory instructions
// [RULE_17] complete fence stalls every later instruction
// [RULE_18] complete fence finishes once accesses drain
// [RULE_19] flush fence discards pipeline and refetches
// [RULE_20] event wait behaves as no operation
// [RULE_21] false condition continues sequentially, no change
// [RULE_22] taken branch discards fetched work, fetches target
`include "bce_consts.svh"
`default_nettype none

module bce_exec (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic                   instr_valid,
    input  wire bce_pkg::bce_instr_t    instr,
    input  wire bce_pkg::bce_flags_t    flags,
    input  wire logic                   mem_idle,
    input  wire logic                   dbg_attached,
    input  wire logic                   dbg_resume,
    input  wire logic                   irq_req,
    input  wire logic                   nmi_req,
    output logic                        instr_ready,
    output logic                        mem_instr_ready,
    output bce_pkg::bce_redirect_t      redirect,
    output bce_pkg::bce_link_t          link,
    output logic                        tbit,
    output logic                        fatal_fault,
    output logic                        debug_halted,
    output logic                        interrupt_mask_bit,
    output logic                        pipe_flush,
    output logic                        irq_take
);

    ////////////////////////////////////////////////////////////////////
    // state
    bce_pkg::bce_state_t    state_r, state_nxt;
    bce_pkg::bce_redirect_t redirect_r, redirect_nxt;
    bce_pkg::bce_link_t     link_r, link_nxt;
    logic                   ready_r, ready_nxt;
    logic                   mem_ready_r, mem_ready_nxt;
    logic                   tbit_r, tbit_nxt;
    logic                   fault_r, fault_nxt;
    logic                   mask_r, mask_nxt;
    logic                   flush_r, flush_nxt;
    logic                   irq_take_r, irq_take_nxt;
    logic                   halt_r;         // debug state, own flop

    ////////////////////////////////////////////////////////////////////
    // decode and address arithmetic
    // memory ops may stall on an order fence while others pass
    wire is_mem   = instr.op == bce_pkg::OP_MEM_ACCESS;
    wire take     = instr_valid & (is_mem ? mem_ready_r : ready_r);
    wire op_br    = take & (instr.op == bce_pkg::OP_BRANCH);
    wire op_brc   = take & (instr.op == bce_pkg::OP_BRANCH_COND);
    wire op_call  = take & (instr.op == bce_pkg::OP_CALL_WITH_RETURN);
    wire op_jreg  = take & (instr.op == bce_pkg::OP_JUMP_REGISTER);
    wire op_creg  = take & (instr.op == bce_pkg::OP_CALL_REGISTER);
    wire op_halt  = take & (instr.op == bce_pkg::OP_DEBUG_HALT);
    wire op_mset  = take & (instr.op == bce_pkg::OP_IRQ_MASK_SET);
    wire op_mclr  = take & (instr.op == bce_pkg::OP_IRQ_MASK_CLEAR);
    wire op_order = take & (instr.op == bce_pkg::OP_MEMORY_ORDER_FENCE);
    wire op_cmplt = take & (instr.op == bce_pkg::OP_MEMORY_COMPLETE_FENCE);
    wire op_flush = take & (instr.op == bce_pkg::OP_FETCH_FLUSH_FENCE);
    wire op_reg   = op_jreg | op_creg;

    // halfword offsets, sign extended then doubled
    wire [31:0] ofs_br = {{(32 - `BCE_OFS_BRANCH_W - 1){
        instr.imm[`BCE_OFS_BRANCH_W-1]}},
        instr.imm[`BCE_OFS_BRANCH_W-1:0], 1'b0};                // RULE_05
    wire [31:0] ofs_brc = {{(32 - `BCE_OFS_COND_W - 1){
        instr.imm[`BCE_OFS_COND_W-1]}},
        instr.imm[`BCE_OFS_COND_W-1:0], 1'b0};                  // RULE_05
    wire [31:0] ofs_call = {{(32 - `BCE_OFS_CALL_W - 1){
        instr.imm[`BCE_OFS_CALL_W-1]}},
        instr.imm[`BCE_OFS_CALL_W-1:0], 1'b0};                  // RULE_05
    wire [31:0] pc_base  = instr.pc + `BCE_PC_AHEAD;
    wire [31:0] tgt_br   = pc_base + ofs_br;
    wire [31:0] tgt_brc  = pc_base + ofs_brc;
    wire [31:0] tgt_call = pc_base + ofs_call;
    wire [31:0] tgt_reg  = {instr.rm_val[31:1], 1'b0};           // RULE_06
    wire        reg_lsb  = instr.rm_val[0];
    wire [31:0] seq_pc   = instr.pc + `BCE_INSN_SIZE;

    ////////////////////////////////////////////////////////////////////
    // condition evaluation, read only: nothing here writes the flags
    function automatic logic cond_pass(input logic [3:0]          cc,
                                       input bce_pkg::bce_flags_t f);
        logic r;
        r = 1'b0;
        case (cc[3:1])
            3'h0: r = f.z;
            3'h1: r = f.c;
            3'h2: r = f.n;
            3'h3: r = f.v;
            3'h4: r = f.c & ~f.z;
            3'h5: r = f.n == f.v;
            3'h6: r = ~f.z & (f.n == f.v);
            default: r = 1'b1;
        endcase
        // odd codes invert, except the always code
        return (cc[3:1] == 3'h7) ? 1'b1 : (r ^ cc[0]);
    endfunction

    // only the conditional branch consults the flags
    wire cond_true = cond_pass(instr.cond, flags);              // RULE_08
    wire brc_taken = op_brc & cond_true;

    ////////////////////////////////////////////////////////////////////
    // next state; the block has no flag write port at all, so every
    // branch, mask, fence and breakpoint leaves nzcv as it was
    always_comb begin                                  // RULE_09 RULE_14
        state_nxt     = state_r;
        redirect_nxt  = '0;
        link_nxt      = '0;
        tbit_nxt      = tbit_r;
        fault_nxt     = 1'b0;
        mask_nxt      = mask_r;
        flush_nxt     = 1'b0;
        // taken branches redirect fetch and drop younger work
        if (op_br) begin
            redirect_nxt = '{valid: 1'b1, target: tgt_br};     // RULE_01
        end
        if (brc_taken) begin
            redirect_nxt = '{valid: 1'b1, target: tgt_brc};    // RULE_22
        end
        // a false condition falls through with nothing written
        if (op_brc & ~cond_true) begin
            redirect_nxt = '0;                                  // RULE_21
        end
        if (op_call) begin
            redirect_nxt = '{valid: 1'b1, target: tgt_call};
            link_nxt = '{we: 1'b1,
                         data: (instr.pc + `BCE_CALL_SIZE) | 32'h1};
        end                                                     // RULE_02
        if (op_reg & ~reg_lsb) begin
            fault_nxt = 1'b1;                                   // RULE_03
        end
        if (op_reg & reg_lsb) begin
            redirect_nxt = '{valid: 1'b1, target: tgt_reg};    // RULE_01
            tbit_nxt = reg_lsb;                                 // RULE_06
        end
        if (op_creg & reg_lsb) begin
            link_nxt = '{we: 1'b1, data: seq_pc | 32'h1};      // RULE_04
        end
        if (op_mset) begin
            mask_nxt = 1'b1;                                    // RULE_12
        end
        if (op_mclr) begin
            mask_nxt = 1'b0;                                    // RULE_12
        end
        // refetch after the flush fence from the next address
        if (op_flush) begin
            flush_nxt    = 1'b1;                                // RULE_19
            redirect_nxt = '{valid: 1'b1, target: seq_pc};
        end
        // event wait is accepted and retires with no effect
        if (take & (instr.op == bce_pkg::OP_EVENT_WAIT)) begin
            redirect_nxt = '0;                                  // RULE_20
        end
        case (state_r)
            bce_pkg::ST_RUN: begin
                if (op_order) begin
                    state_nxt = bce_pkg::ST_ORDER;              // RULE_15
                end
                if (op_cmplt) begin
                    state_nxt = bce_pkg::ST_COMPLETE;           // RULE_17
                end
            end
            // memory ops wait; other instructions keep flowing
            bce_pkg::ST_ORDER: begin
                if (op_cmplt) begin
                    state_nxt = bce_pkg::ST_COMPLETE;
                end else if (mem_idle) begin
                    state_nxt = bce_pkg::ST_RUN;                // RULE_16
                end
            end
            bce_pkg::ST_COMPLETE: begin
                if (mem_idle) begin
                    state_nxt = bce_pkg::ST_RUN;                // RULE_18
                end
            end
            bce_pkg::ST_HALT: begin
                if (dbg_resume) begin
                    state_nxt = bce_pkg::ST_RUN;
                end
            end
            default: state_nxt = bce_pkg::ST_RUN;
        endcase
        // the immediate byte is never looked at; kept after the fence
        // states so that a breakpoint under an order fence still halts
        if (op_halt) begin
            if (dbg_attached) begin
                state_nxt = bce_pkg::ST_HALT;                   // RULE_10
            end else begin
                fault_nxt = 1'b1;                               // RULE_11
            end
        end
        // readiness is registered, so it looks one state ahead
        ready_nxt     = (state_nxt == bce_pkg::ST_RUN) |
                        (state_nxt == bce_pkg::ST_ORDER);       // RULE_17
        mem_ready_nxt = state_nxt == bce_pkg::ST_RUN;           // RULE_15
    end

    // the unmaskable request bypasses the mask bit
    assign irq_take_nxt = nmi_req | (irq_req & ~mask_r);        // RULE_13

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= bce_pkg::ST_RUN;
            redirect_r  <= '0;
            link_r      <= '0;
            ready_r     <= 1'b1;
            mem_ready_r <= 1'b1;
            tbit_r      <= `BCE_TBIT_RESET;
            fault_r     <= 1'b0;
            mask_r      <= `BCE_MASK_RESET;
            flush_r     <= 1'b0;
            irq_take_r  <= 1'b0;
            halt_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            redirect_r  <= redirect_nxt;
            link_r      <= link_nxt;
            ready_r     <= ready_nxt;
            mem_ready_r <= mem_ready_nxt;
            tbit_r      <= tbit_nxt;
            fault_r     <= fault_nxt;
            mask_r      <= mask_nxt;
            flush_r     <= flush_nxt;
            irq_take_r  <= irq_take_nxt;
            halt_r      <= state_nxt == bce_pkg::ST_HALT;
        end
    end

    // every output comes straight from a flip-flop
    assign instr_ready        = ready_r;
    assign mem_instr_ready    = mem_ready_r;
    assign redirect           = redirect_r;
    assign link               = link_r;
    assign tbit               = tbit_r;
    assign fatal_fault        = fault_r;
    assign debug_halted       = halt_r;
    assign interrupt_mask_bit = mask_r;
    assign pipe_flush         = flush_r;
    assign irq_take           = irq_take_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_reg_fault;
        @(posedge ref_clk) disable iff (!resetn)
        op_reg & ~reg_lsb |=> fatal_fault & ~redirect.valid & ~link.we;
    endproperty
    a_reg_fault: assert property (p_reg_fault)                // RULE_03
        else $error("register branch with even target did not fault");
    property p_call_link;
        @(posedge ref_clk) disable iff (!resetn)
        op_call |=> link.we &&
            link.data == (($past(instr.pc) + `BCE_CALL_SIZE) | 32'h1);
    endproperty
    a_call_link: assert property (p_call_link)                // RULE_02
        else $error("call did not write the return address");
    property p_link_odd;
        @(posedge ref_clk) disable iff (!resetn)
        link.we |-> link.data[0] && ($past(op_call) || $past(op_creg));
    endproperty
    a_link_odd: assert property (p_link_odd)                  // RULE_04
        else $error("link written with bit0 clear or without a call");
    property p_reg_target;
        @(posedge ref_clk) disable iff (!resetn)
        op_reg & reg_lsb |=> redirect.valid & tbit & ~redirect.target[0]
            && redirect.target[31:1] == $past(instr.rm_val[31:1]);
    endproperty
    a_reg_target: assert property (p_reg_target)              // RULE_06
        else $error("register branch target or t bit wrong");
    property p_cond_false;
        @(posedge ref_clk) disable iff (!resetn)
        op_brc & ~cond_true |=> ~redirect.valid & ~link.we & ~fatal_fault;
    endproperty
    a_cond_false: assert property (p_cond_false)              // RULE_21
        else $error("untaken conditional branch changed state");
    property p_mask_set;
        @(posedge ref_clk) disable iff (!resetn)
        op_mset ##1 ~op_mclr |=> interrupt_mask_bit;
    endproperty
    a_mask_set: assert property (p_mask_set)                  // RULE_12
        else $error("mask bit not held after mask set");
    property p_nmi;
        @(posedge ref_clk) disable iff (!resetn)
        nmi_req |=> irq_take;
    endproperty
    a_nmi: assert property (p_nmi)                            // RULE_13
        else $error("unmaskable request was blocked");
    property p_complete_stall;
        @(posedge ref_clk) disable iff (!resetn)
        op_cmplt ##1 ~mem_idle[*2] |-> ~instr_ready & ~mem_instr_ready;
    endproperty
    a_complete_stall: assert property (p_complete_stall)      // RULE_17
        else $error("instruction accepted during completion fence");
    property p_flush;
        @(posedge ref_clk) disable iff (!resetn)
        op_flush |=> pipe_flush && redirect.valid &&
            redirect.target == $past(seq_pc);
    endproperty
    a_flush: assert property (p_flush)                        // RULE_19
        else $error("flush fence did not flush and refetch");
    property p_halt;
        @(posedge ref_clk) disable iff (!resetn)
        op_halt & dbg_attached |=> debug_halted & ~instr_ready;
    endproperty
    a_halt: assert property (p_halt)                          // RULE_10
        else $error("breakpoint did not halt with debugger");

endmodule
`default_nettype wire

// ### rtl/bce_pkg.sv
// types shared by the branch and control execution block
// assumes the constants header is compiled alongside
`default_nettype none
package bce_pkg;

    typedef enum logic [3:0] {
        OP_OTHER                 = 4'h0,
        OP_MEM_ACCESS            = 4'h1,
        OP_BRANCH                = 4'h2,
        OP_BRANCH_COND           = 4'h3,
        OP_CALL_WITH_RETURN      = 4'h4,
        OP_JUMP_REGISTER         = 4'h5,
        OP_CALL_REGISTER         = 4'h6,
        OP_DEBUG_HALT            = 4'h7,
        OP_IRQ_MASK_SET          = 4'h8,
        OP_IRQ_MASK_CLEAR        = 4'h9,
        OP_MEMORY_ORDER_FENCE    = 4'ha,
        OP_MEMORY_COMPLETE_FENCE = 4'hb,
        OP_FETCH_FLUSH_FENCE     = 4'hc,
        OP_EVENT_WAIT            = 4'hd
    } bce_op_t;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_ORDER    = 2'b01,
        ST_COMPLETE = 2'b10,
        ST_HALT     = 2'b11
    } bce_state_t;

    // one decoded instruction with its operands
    typedef struct packed {
        bce_op_t     op;
        logic [3:0]  cond;
        logic [3:0]  rm_idx;
        logic [23:0] imm;
        logic [31:0] pc;
        logic [31:0] rm_val;
    } bce_instr_t;

    // condition flags, negative zero carry overflow
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } bce_flags_t;

    // fetch redirect request
    typedef struct packed {
        logic        valid;
        logic [31:0] target;
    } bce_redirect_t;

    // link register write
    typedef struct packed {
        logic        we;
        logic [31:0] data;
    } bce_link_t;

endpackage
`default_nettype wire

// ### tb/bce_mem_model.sv
// memory system stand-in: reports busy for a set number of cycles
// assumes the bench pulses start for one cycle at a falling edge
`default_nettype none
module bce_mem_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic [7:0] hold,
    output logic            mem_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count_r;

    ////////////////////////////////////////////////////////////////////
    // outstanding accesses drain one per cycle; idle only when none left
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= 8'h00;
        end else if (start) begin
            count_r <= hold;
        end else if (count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
        end
    end
    assign mem_idle = (count_r == 8'h00);
endmodule
`default_nettype wire

// ### tb/branch_and_control_exec_test.sv
// self-checking bench for the branch and control execution stage
// assumes outputs are registered at the edge that takes an instruction
`default_nettype none
module branch_and_control_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    bce_pkg::bce_instr_t instr = '0;
    bce_pkg::bce_flags_t flags = 4'h4;
    logic mem_idle, dbg_attached = 1'b0, dbg_resume = 1'b0;
    logic irq_req = 1'b0, nmi_req = 1'b0, mem_start = 1'b0;
    logic instr_ready, mem_instr_ready, tbit, fatal_fault;
    logic debug_halted, interrupt_mask_bit, pipe_flush, irq_take;
    bce_pkg::bce_redirect_t redirect;
    bce_pkg::bce_link_t     link;
    int errors = 0, checks_done = 0, cyc = 0;

    always #12.5 ref_clk = ~ref_clk;

    bce_exec dut (.ref_clk(ref_clk), .resetn(resetn),
        .instr_valid(instr_valid), .instr(instr), .flags(flags),
        .mem_idle(mem_idle), .dbg_attached(dbg_attached),
        .dbg_resume(dbg_resume), .irq_req(irq_req), .nmi_req(nmi_req),
        .instr_ready(instr_ready), .mem_instr_ready(mem_instr_ready),
        .redirect(redirect), .link(link), .tbit(tbit),
        .fatal_fault(fatal_fault), .debug_halted(debug_halted),
        .interrupt_mask_bit(interrupt_mask_bit),
        .pipe_flush(pipe_flush), .irq_take(irq_take));

    bce_mem_model mem (.ref_clk(ref_clk), .resetn(resetn),
        .start(mem_start), .hold(8'h05), .mem_idle(mem_idle));

    ////////////////////////////////////////////////////////////////////
    // result comparisons, one per width of result
    task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // offer one instruction from a falling edge; returns at the falling
    // edge after the taking edge, where the registered answer is settled
    task automatic go(input bce_pkg::bce_op_t op, input logic [3:0] cond,
                      input logic [23:0] imm, input logic [31:0] pc,
                      input logic [31:0] rm);
        int n;
        n = 0;
        // let an edge pass with valid low, so two offers never merge
        @(negedge ref_clk);
        while ((op == bce_pkg::OP_MEM_ACCESS ? mem_instr_ready
                                             : instr_ready) !== 1'b1
               && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        instr.op = op;
        instr.cond = cond;
        instr.rm_idx = 4'h3;
        instr.imm = imm;
        instr.pc = pc;
        instr.rm_val = rm;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // direct branches at the negative extreme of each offset field, both extremes for the conditional one
    task automatic t_direct;
        go(bce_pkg::OP_BRANCH, 4'h1, 24'h000400, 32'h0000_1000, 32'h0);
        chk_word(redirect, {1'b1, 32'h0000_0804});
        go(bce_pkg::OP_BRANCH_COND, 4'h0, 24'h00007f, 32'h0000_1000, 32'h0);
        chk_word(redirect, {1'b1, 32'h0000_1102});
        go(bce_pkg::OP_BRANCH_COND, 4'h0, 24'h000080, 32'h0000_1000, 32'h0);
        chk_word(redirect, {1'b1, 32'h0000_0f04});
        go(bce_pkg::OP_BRANCH_COND, 4'h1, 24'h000010, 32'h0000_1000, 32'h0);
        chk_bit(redirect.valid, 1'b0);
        chk_bit(link.we, 1'b0);
        go(bce_pkg::OP_CALL_WITH_RETURN, 4'h1, 24'h800000, 32'h0200_0000,
           32'h0);
        chk_word(redirect, {1'b1, 32'h0100_0004});
        chk_word(link, {1'b1, 32'h0200_0005});
        @(negedge ref_clk);
        chk_bit(link.we, 1'b0);
        $display("test direct done");
    endtask

    // register targets: state bit taken, bit0 clear faults
    task automatic t_register;
        go(bce_pkg::OP_JUMP_REGISTER, 4'he, 24'h0, 32'h100, 32'h0000_2001);
        chk_word(redirect, {1'b1, 32'h0000_2000});
        chk_bit(tbit, 1'b1);
        go(bce_pkg::OP_JUMP_REGISTER, 4'he, 24'h0, 32'h100, 32'h0000_3000);
        chk_bit(fatal_fault, 1'b1);
        chk_bit(redirect.valid, 1'b0);
        go(bce_pkg::OP_CALL_REGISTER, 4'he, 24'h0, 32'h400, 32'h0000_5003);
        chk_word(redirect, {1'b1, 32'h0000_5002});
        chk_word(link, {1'b1, 32'h0000_0403});
        go(bce_pkg::OP_CALL_REGISTER, 4'he, 24'h0, 32'h400, 32'h0000_5002);
        chk_bit(fatal_fault, 1'b1);
        chk_bit(link.we, 1'b0);
        $display("test register done");
    endtask

    // mask set and clear, unmaskable request passes the mask
    task automatic t_mask;
        irq_req = 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk_bit(irq_take, 1'b1);
        go(bce_pkg::OP_IRQ_MASK_SET, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(interrupt_mask_bit, 1'b1);
        @(negedge ref_clk);
        chk_bit(irq_take, 1'b0);
        nmi_req = 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk_bit(irq_take, 1'b1);
        nmi_req = 1'b0;
        go(bce_pkg::OP_IRQ_MASK_CLEAR, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(interrupt_mask_bit, 1'b0);
        @(negedge ref_clk);
        chk_bit(irq_take, 1'b1);
        irq_req = 1'b0;
        $display("test mask done");
    endtask

    // barriers against a busy memory system
    task automatic t_fence;
        int n;
        mem_start = 1'b1;
        @(negedge ref_clk);
        mem_start = 1'b0;
        go(bce_pkg::OP_MEMORY_ORDER_FENCE, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(mem_instr_ready, 1'b0);
        chk_bit(instr_ready, 1'b1);
        go(bce_pkg::OP_OTHER, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(mem_instr_ready, 1'b0);
        // a later access may only be taken once the earlier ones drained
        go(bce_pkg::OP_MEM_ACCESS, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(mem_idle, 1'b1);
        n = 0;
        while (mem_idle !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
        chk_bit(mem_instr_ready, 1'b1);
        mem_start = 1'b1;
        @(negedge ref_clk);
        mem_start = 1'b0;
        go(bce_pkg::OP_MEMORY_COMPLETE_FENCE, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(instr_ready, 1'b0);
        @(negedge ref_clk);
        chk_bit(instr_ready, 1'b0);
        chk_bit(mem_instr_ready, 1'b0);
        n = 0;
        while (mem_idle !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
        chk_bit(instr_ready, 1'b1);
        go(bce_pkg::OP_FETCH_FLUSH_FENCE, 4'he, 24'h0, 32'h500, 32'h0);
        chk_bit(pipe_flush, 1'b1);
        chk_word(redirect, {1'b1, 32'h0000_0502});
        go(bce_pkg::OP_EVENT_WAIT, 4'he, 24'h0, 32'h600, 32'h0);
        chk_bit(redirect.valid, 1'b0);
        chk_bit(instr_ready, 1'b1);
        $display("test fence done");
    endtask

    // breakpoint with and without a debugger present
    task automatic t_debug;
        dbg_attached = 1'b1;
        go(bce_pkg::OP_DEBUG_HALT, 4'he, 24'h0000ff, 32'h0, 32'h0);
        chk_bit(debug_halted, 1'b1);
        chk_bit(instr_ready, 1'b0);
        chk_bit(fatal_fault, 1'b0);
        dbg_resume = 1'b1;
        repeat (2) @(negedge ref_clk);
        dbg_resume = 1'b0;
        chk_bit(debug_halted, 1'b0);
        dbg_attached = 1'b0;
        go(bce_pkg::OP_DEBUG_HALT, 4'he, 24'h0, 32'h0, 32'h0);
        chk_bit(fatal_fault, 1'b1);
        chk_bit(debug_halted, 1'b0);
        $display("test debug done");
    endtask

    ////////////////////////////////////////////////////////////////////
    // a hang costs a mismatch; the whole run needs well under 600 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up;
        end
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        chk_bit(tbit, 1'b1);
        chk_bit(interrupt_mask_bit, 1'b0);
        @(negedge ref_clk);
        t_direct;
        t_register;
        t_mask;
        t_fence;
        t_debug;
        wrap_up;
    end
endmodule
`default_nettype wire
